// ===== hdl/pll_clk_pkg.sv
// Purpose: Shared constants for the PLL and clock divider configuration block
// Assumes: Byte-wide registers reached through a simple synchronous write/read port
// Notes: Reserved bits are masked on write and read as zero
package pll_clk_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DIV_W = 7;
  localparam int SEL_W = 3;
  localparam int P_W = 4;
  localparam int J_W = 6;
  localparam int DU_W = 6;
  localparam int DL_W = 8;
  localparam int D_W = DU_W + DL_W;
  localparam int R_W = 4;
  localparam int MULT_W = J_W + R_W + 1;
  localparam int FRACR_W = D_W + R_W + 1;

  localparam logic [ADDR_W-1:0] OFF_PRE_DIV = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INT_MULT = 8'h15;
  localparam logic [ADDR_W-1:0] OFF_FRAC_UP = 8'h16;
  localparam logic [ADDR_W-1:0] OFF_FRAC_LO = 8'h17;
  localparam logic [ADDR_W-1:0] OFF_R_MULT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PROC_DIV = 8'h1b;
  localparam logic [ADDR_W-1:0] OFF_CONV_DIV = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_CP_DIV = 8'h1d;

  localparam logic [DATA_W-1:0] MASK_PRE_DIV = 8'h0f;
  localparam logic [DATA_W-1:0] MASK_INT_MULT = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_FRAC_UP = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_FRAC_LO = 8'hff;
  localparam logic [DATA_W-1:0] MASK_R_MULT = 8'h0f;
  localparam logic [DATA_W-1:0] MASK_DIV = 8'h7f;

  localparam logic [DATA_W-1:0] RST_PRE_DIV = 8'h00;
  localparam logic [DATA_W-1:0] RST_INT_MULT = 8'h08;
  localparam logic [DATA_W-1:0] RST_FRAC_UP = 8'h00;
  localparam logic [DATA_W-1:0] RST_FRAC_LO = 8'h00;
  localparam logic [DATA_W-1:0] RST_R_MULT = 8'h00;
  localparam logic [DATA_W-1:0] RST_PROC_DIV = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONV_DIV = 8'h01;
  localparam logic [DATA_W-1:0] RST_CP_DIV = 8'h01;

  localparam logic [SEL_W-1:0] SRC_CONV = 3'h0;
  localparam logic [SEL_W-1:0] SRC_MASTER = 3'h1;
  localparam logic [SEL_W-1:0] SRC_PLL = 3'h2;
  localparam logic [SEL_W-1:0] SRC_OSC = 3'h3;
  localparam logic [SEL_W-1:0] SRC_MCLK = 3'h4;
  localparam logic [SEL_W-1:0] SRC_SCLK = 3'h5;
  localparam logic [SEL_W-1:0] SRC_GPIO = 3'h6;
endpackage : pll_clk_pkg

// ===== hdl/div_if.sv
// Purpose: Carrier between the configuration top and one clock divider
// Assumes: Source clock arrives as a one-cycle tick in the clk domain
// Notes: Ratio field is the raw code; the divider adds one itself
interface div_if;
  logic [pll_clk_pkg::DIV_W-1:0] ratio;
  logic srcTick;
  logic outTick;
  modport ctrl (output ratio, output srcTick, input outTick);
  modport div (input ratio, input srcTick, output outTick);
endinterface : div_if

// ===== hdl/clk_divider.sv
// Purpose: Divide a tick stream by field value plus one
// Assumes: Ratio may change at any time
// Notes: Compare is >= so a shrunk ratio wraps at once instead of running to 127
module clk_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Divider link
  div_if.div dv
);
  logic [pll_clk_pkg::DIV_W-1:0] cnt_r;
  logic outTick_r;
  wire atWrap = (cnt_r >= dv.ratio);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      outTick_r <= 1'b0;
    end else if (ce) begin
      outTick_r <= dv.srcTick && atWrap;
      if (dv.srcTick) begin
        cnt_r <= atWrap ? '0 : cnt_r + 1'b1;
      end
    end
  end

  assign dv.outTick = outTick_r;

  property p_wrapTick;
    @(posedge clk) disable iff (!nrst)
      ce && dv.srcTick && atWrap |=> outTick_r && (cnt_r == '0);
  endproperty
  a_wrapTick: assert property (p_wrapTick) else $error("Divider missed its wrap");

  property p_noSpurious;
    @(posedge clk) disable iff (!nrst)
      ce && !(dv.srcTick && atWrap) |=> !outTick_r;
  endproperty
  a_noSpurious: assert property (p_noSpurious) else $error("Divider tick without wrap");
endmodule : clk_divider

// ===== hdl/pll_clk_config.sv
// Purpose: PLL factor and clock divider configuration with three tick dividers
// Assumes: Register port and source ticks are synchronous to clk
// Notes: Auto-set replaces every field with module parameters; stored values stay intact
// Overview of operation
// - Pre-divider P equals four-bit field plus one, P from 1 to 16.
// - Multiplier J equals six-bit field value, resets to binary 001000.
// - Overall PLL multiplication is J.D times R.
// - R multiplier equals four-bit field plus one, 1 to 16.
// - Processor clock is its source divided by field plus one.
// - Converter clock is its source divided by field plus one.
// - Charge-pump clock is its source divided by field plus one.
// - In auto-set mode all these fields are ignored and derived internally.
// - Three-bit selector picks charge-pump source; codes above six mute it.
module pll_clk_config #(
  parameter logic [3:0] AUTO_PRE = 4'h0,
  parameter logic [5:0] AUTO_INT = 6'h08,
  parameter logic [13:0] AUTO_FRAC = 14'h0000,
  parameter logic [3:0] AUTO_R = 4'h0,
  parameter logic [6:0] AUTO_PROC = 7'h00,
  parameter logic [6:0] AUTO_CONV = 7'h01,
  parameter logic [6:0] AUTO_CP = 7'h01
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic wrEn,
  input wire logic [pll_clk_pkg::ADDR_W-1:0] addr,
  input wire logic [pll_clk_pkg::DATA_W-1:0] wrData,
  output logic [pll_clk_pkg::DATA_W-1:0] rdData,
  // Mode and source selection
  input wire logic autoSetEn,
  input wire logic [pll_clk_pkg::SEL_W-1:0] chargePumpSrcSelect,
  // Source ticks
  input wire logic procSrcTick,
  input wire logic convSrcTick,
  input wire logic masterTick,
  input wire logic pllTick,
  input wire logic oscTick,
  input wire logic mclkTick,
  input wire logic sclkTick,
  input wire logic gpioTick,
  // Effective PLL settings
  output logic [pll_clk_pkg::P_W:0] pllPreDivRatio,
  output logic [pll_clk_pkg::J_W-1:0] pllIntMult,
  output logic [pll_clk_pkg::D_W-1:0] pllFrac,
  output logic [pll_clk_pkg::R_W:0] pllRMult,
  output logic [pll_clk_pkg::MULT_W-1:0] pllTotalInt,
  output logic [pll_clk_pkg::FRACR_W-1:0] pllTotalFrac,
  // Divided clock ticks
  output logic procTick,
  output logic convTick,
  output logic chargePumpTick
);
  logic [7:0] preReg_r, intReg_r, fracUpReg_r, fracLoReg_r, rReg_r;
  logic [7:0] procReg_r, convReg_r, cpReg_r;
  logic [7:0] rdData_r;
  logic [pll_clk_pkg::P_W:0] pre_r;
  logic [pll_clk_pkg::J_W-1:0] int_r;
  logic [pll_clk_pkg::D_W-1:0] frac_r;
  logic [pll_clk_pkg::R_W:0] rMul_r;
  logic [pll_clk_pkg::MULT_W-1:0] totInt_r;
  logic [pll_clk_pkg::FRACR_W-1:0] totFrac_r;

  div_if procLink ();
  div_if convLink ();
  div_if cpLink ();

  // Register write decode
  wire wrGo = ce && wrEn;
  wire hitPre = addr == pll_clk_pkg::OFF_PRE_DIV;
  wire hitInt = addr == pll_clk_pkg::OFF_INT_MULT;
  wire hitUp = addr == pll_clk_pkg::OFF_FRAC_UP;
  wire hitLo = addr == pll_clk_pkg::OFF_FRAC_LO;
  wire hitR = addr == pll_clk_pkg::OFF_R_MULT;
  wire hitProc = addr == pll_clk_pkg::OFF_PROC_DIV;
  wire hitConv = addr == pll_clk_pkg::OFF_CONV_DIV;
  wire hitCp = addr == pll_clk_pkg::OFF_CP_DIV;

  // Field selection; auto-set overrides without touching stored values
  wire [3:0] preField = autoSetEn ? AUTO_PRE : preReg_r[3:0];
  wire [5:0] intField = autoSetEn ? AUTO_INT : intReg_r[5:0];
  wire [13:0] fracField = autoSetEn ? AUTO_FRAC : {fracUpReg_r[5:0], fracLoReg_r};
  wire [3:0] rField = autoSetEn ? AUTO_R : rReg_r[3:0];
  wire [6:0] procField = autoSetEn ? AUTO_PROC : procReg_r[6:0];
  wire [6:0] convField = autoSetEn ? AUTO_CONV : convReg_r[6:0];
  wire [6:0] cpField = autoSetEn ? AUTO_CP : cpReg_r[6:0];

  // Prohibited codes are passed through unchecked; software keeps them out
  wire [4:0] preNxt = {1'b0, preField} + 5'h01;
  wire [4:0] rNxt = {1'b0, rField} + 5'h01;
  // Integer product J*R, and D*R in units of 1/10000
  wire [10:0] totInt_nxt = 11'(intField) * 11'(rNxt);
  wire [18:0] totFrac_nxt = 19'(fracField) * 19'(rNxt);

  // Charge-pump source mux; reserved codes leave the divider idle
  logic cpSrc;
  always_comb begin
    cpSrc = 1'b0;
    unique case (chargePumpSrcSelect)
      pll_clk_pkg::SRC_CONV: cpSrc = convLink.outTick;
      pll_clk_pkg::SRC_MASTER: cpSrc = masterTick;
      pll_clk_pkg::SRC_PLL: cpSrc = pllTick;
      pll_clk_pkg::SRC_OSC: cpSrc = oscTick;
      pll_clk_pkg::SRC_MCLK: cpSrc = mclkTick;
      pll_clk_pkg::SRC_SCLK: cpSrc = sclkTick;
      pll_clk_pkg::SRC_GPIO: cpSrc = gpioTick;
      default: cpSrc = 1'b0;
    endcase
  end

  // Readback: reserved bits zero, unmapped addresses read zero
  wire [7:0] rdSel = hitPre ? preReg_r : hitInt ? intReg_r : hitUp ? fracUpReg_r :
                     hitLo ? fracLoReg_r : hitR ? rReg_r : hitProc ? procReg_r :
                     hitConv ? convReg_r : hitCp ? cpReg_r : 8'h00;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      preReg_r <= pll_clk_pkg::RST_PRE_DIV;
      intReg_r <= pll_clk_pkg::RST_INT_MULT;
      fracUpReg_r <= pll_clk_pkg::RST_FRAC_UP;
      fracLoReg_r <= pll_clk_pkg::RST_FRAC_LO;
      rReg_r <= pll_clk_pkg::RST_R_MULT;
      procReg_r <= pll_clk_pkg::RST_PROC_DIV;
      convReg_r <= pll_clk_pkg::RST_CONV_DIV;
      cpReg_r <= pll_clk_pkg::RST_CP_DIV;
    end else if (wrGo) begin
      if (hitPre) preReg_r <= wrData & pll_clk_pkg::MASK_PRE_DIV;
      if (hitInt) intReg_r <= wrData & pll_clk_pkg::MASK_INT_MULT;
      if (hitUp) fracUpReg_r <= wrData & pll_clk_pkg::MASK_FRAC_UP;
      if (hitLo) fracLoReg_r <= wrData & pll_clk_pkg::MASK_FRAC_LO;
      if (hitR) rReg_r <= wrData & pll_clk_pkg::MASK_R_MULT;
      if (hitProc) procReg_r <= wrData & pll_clk_pkg::MASK_DIV;
      if (hitConv) convReg_r <= wrData & pll_clk_pkg::MASK_DIV;
      if (hitCp) cpReg_r <= wrData & pll_clk_pkg::MASK_DIV;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_r <= 8'h00;
      pre_r <= 5'h01;
      int_r <= pll_clk_pkg::RST_INT_MULT[5:0];
      frac_r <= 14'h0000;
      rMul_r <= 5'h01;
      totInt_r <= 11'h008;
      totFrac_r <= 19'h00000;
    end else if (ce) begin
      rdData_r <= rdSel;
      pre_r <= preNxt;
      int_r <= intField;
      frac_r <= fracField;
      rMul_r <= rNxt;
      totInt_r <= totInt_nxt;
      totFrac_r <= totFrac_nxt;
    end
  end

  assign procLink.ratio = procField;
  assign procLink.srcTick = procSrcTick;
  assign convLink.ratio = convField;
  assign convLink.srcTick = convSrcTick;
  assign cpLink.ratio = cpField;
  assign cpLink.srcTick = cpSrc;

  clk_divider procDiv (.clk(clk), .nrst(nrst), .ce(ce), .dv(procLink));
  clk_divider convDiv (.clk(clk), .nrst(nrst), .ce(ce), .dv(convLink));
  clk_divider cpDiv (.clk(clk), .nrst(nrst), .ce(ce), .dv(cpLink));

  assign rdData = rdData_r;
  assign pllPreDivRatio = pre_r;
  assign pllIntMult = int_r;
  assign pllFrac = frac_r;
  assign pllRMult = rMul_r;
  assign pllTotalInt = totInt_r;
  assign pllTotalFrac = totFrac_r;
  assign procTick = procLink.outTick;
  assign convTick = convLink.outTick;
  assign chargePumpTick = cpLink.outTick;

  sequence s_manual;
    ce && !autoSetEn;
  endsequence
  sequence s_auto;
    ce && autoSetEn;
  endsequence

  property p_preDiv;
    @(posedge clk) disable iff (!nrst)
      s_manual |=> pllPreDivRatio == {1'b0, $past(preReg_r[3:0])} + 5'h01;
  endproperty
  a_preDiv: assert property (p_preDiv) else $error("P not field plus one");

  property p_intReset;
    @(posedge clk) !nrst |=> intReg_r == pll_clk_pkg::RST_INT_MULT;
  endproperty
  a_intReset: assert property (p_intReset) else $error("J reset value wrong");

  property p_frac;
    @(posedge clk) disable iff (!nrst)
      s_manual |=> pllFrac == {$past(fracUpReg_r[5:0]), $past(fracLoReg_r)};
  endproperty
  a_frac: assert property (p_frac) else $error("D halves joined wrongly");

  property p_totInt;
    @(posedge clk) disable iff (!nrst)
      ce ##1 ce |=> pllTotalInt == 11'(pllIntMult) * 11'(pllRMult);
  endproperty
  a_totInt: assert property (p_totInt) else $error("J times R wrong");

  property p_rMul;
    @(posedge clk) disable iff (!nrst)
      s_manual |=> pllRMult == {1'b0, $past(rReg_r[3:0])} + 5'h01;
  endproperty
  a_rMul: assert property (p_rMul) else $error("R not field plus one");

  property p_autoSet;
    @(posedge clk) disable iff (!nrst)
      s_auto |=> pllIntMult == AUTO_INT && pllFrac == AUTO_FRAC &&
        pllPreDivRatio == {1'b0, AUTO_PRE} + 5'h01;
  endproperty
  a_autoSet: assert property (p_autoSet) else $error("Auto-set not applied");

  property p_cpMute;
    @(posedge clk) disable iff (!nrst)
      ce && chargePumpSrcSelect == 3'h7 |=> !chargePumpTick;
  endproperty
  a_cpMute: assert property (p_cpMute) else $error("Muted source still ticks");

  property p_procWrite;
    @(posedge clk) disable iff (!nrst)
      wrGo && hitProc |=> procReg_r == ($past(wrData) & 8'h7f);
  endproperty
  a_procWrite: assert property (p_procWrite) else $error("Divider field write lost");

  property p_divOne;
    @(posedge clk) disable iff (!nrst)
      ce && !autoSetEn && convReg_r[6:0] == 7'h00 && convSrcTick |=> convTick;
  endproperty
  a_divOne: assert property (p_divOne) else $error("Divide by one missed");
endmodule : pll_clk_config

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the PLL and clock divider configuration block
// Assumes: Inputs change 1 ns after each rising edge; auto-set values are test parameters
// Notes: Divider counts use whole multiples of the ratio so no count is left mid-wrap
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic wrEn = 1'b0;
  logic [pll_clk_pkg::ADDR_W-1:0] addr = 8'h00;
  logic [pll_clk_pkg::DATA_W-1:0] wrData = 8'h00;
  logic autoSetEn = 1'b0;
  logic [pll_clk_pkg::SEL_W-1:0] cpSel = 3'h0;
  logic [7:0] src = 8'h00;
  logic [pll_clk_pkg::DATA_W-1:0] rdData;
  logic [pll_clk_pkg::P_W:0] pRatio;
  logic [pll_clk_pkg::J_W-1:0] jMult;
  logic [pll_clk_pkg::D_W-1:0] dFrac;
  logic [pll_clk_pkg::R_W:0] rMult;
  logic [pll_clk_pkg::MULT_W-1:0] totInt;
  logic [pll_clk_pkg::FRACR_W-1:0] totFrac;
  logic procTick;
  logic convTick;
  logic chargePumpTick;
  int mismatches = 0;
  int n_checks = 0;
  int nProc = 0;
  int nConv = 0;
  int nCp = 0;
  logic [7:0] offs [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1b, 8'h1c, 8'h1d};
  logic [7:0] rstv [8] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [7:0] wrv [8] = '{8'hfe, 8'hff, 8'he7, 8'h0f, 8'hff, 8'hff, 8'h80, 8'h83};
  logic [7:0] expv [8] = '{8'h0e, 8'h3f, 8'h27, 8'h0f, 8'h0f, 8'h7f, 8'h00, 8'h03};

  // PLL and processor auto values differ from reset; converter and pump keep defaults
  pll_clk_config #(
    .AUTO_PRE(4'h3), .AUTO_INT(6'h0c), .AUTO_FRAC(14'h0005), .AUTO_R(4'h1),
    .AUTO_PROC(7'h01)
  ) pll_clk_config_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .wrEn(wrEn), .addr(addr), .wrData(wrData),
    .rdData(rdData), .autoSetEn(autoSetEn), .chargePumpSrcSelect(cpSel),
    .procSrcTick(src[0]), .convSrcTick(src[1]), .masterTick(src[2]), .pllTick(src[3]),
    .oscTick(src[4]), .mclkTick(src[5]), .sclkTick(src[6]), .gpioTick(src[7]),
    .pllPreDivRatio(pRatio), .pllIntMult(jMult), .pllFrac(dFrac), .pllRMult(rMult),
    .pllTotalInt(totInt), .pllTotalFrac(totFrac),
    .procTick(procTick), .convTick(convTick), .chargePumpTick(chargePumpTick)
  );

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (procTick === 1'b1) nProc++;
    if (convTick === 1'b1) nConv++;
    if (chargePumpTick === 1'b1) nCp++;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Idle cycles; the only place ticks drop, and with rd one of two places strobes drop
  task automatic step(input int n);
    wrEn = 1'b0;
    src = 8'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : step

  // Strobe stays high across back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wrEn = 1'b0;
    addr = a;
    @(posedge clk);
    #1;
    chk(rdData, exp);
  endtask : rd

  task automatic chkSet(input int p, input int j, input int d, input int r);
    chk(pRatio, p);
    chk(jMult, j);
    chk(dFrac, d);
    chk(rMult, r);
    chk(totInt, j * r);
    chk(totFrac, d * r);
  endtask : chkSet

  task automatic pulse(input logic [7:0] m, input int n);
    nProc = 0;
    nConv = 0;
    nCp = 0;
    repeat (n) begin
      src = m;
      @(posedge clk);
      #1;
    end
    step(4);
  endtask : pulse

  task automatic chkReset;
    for (int i = 0; i < 8; i++) rd(offs[i], rstv[i]);
    chkSet(1, 8, 0, 1);
  endtask : chkReset

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    chkReset();
    // Boundary codes, reserved bits set; fraction lands on 9999
    for (int i = 0; i < 8; i++) wr(offs[i], wrv[i]);
    step(2);
    chkSet(15, 63, 9999, 16);
    for (int i = 0; i < 8; i++) rd(offs[i], expv[i]);
    wr(8'h19, 8'h5a);
    rd(8'h19, 8'h00);
    rd(8'h14, 8'h0e);
    pulse(8'h01, 256);
    chk(nProc, 2);
    pulse(8'h02, 5);
    chk(nConv, 5);
    wr(8'h1c, 8'h03);
    step(1);
    pulse(8'h02, 12);
    chk(nConv, 3);
    wr(8'h1c, 8'h00);
    step(1);
    // Converter divides by one, so code 0 sees one tick per converter tick
    for (int s = 0; s < 8; s++) begin
      cpSel = s[2:0];
      pulse((s < 7) ? (8'h02 << s) : 8'hfe, 8);
      chk(nCp, (s < 7) ? 2 : 0);
    end
    autoSetEn = 1'b1;
    step(2);
    chkSet(4, 12, 5, 2);
    rd(8'h15, 8'h3f);
    // Stored converter ratio 0 and pump ratio 3 would give 4 and 1 here
    cpSel = 3'h0;
    pulse(8'h03, 4);
    chk(nProc, 2);
    chk(nConv, 2);
    chk(nCp, 1);
    autoSetEn = 1'b0;
    step(2);
    chk(pRatio, 15);
    ce = 1'b0;
    wr(8'h15, 8'h01);
    step(1);
    ce = 1'b1;
    rd(8'h15, 8'h3f);
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(1);
    chkReset();
    report_and_stop();
  end
endmodule : tb_top
